// File: verilog/pec_phy_error_counters.sv
`default_nettype none

module pec_phy_error_counters
	import pec_pkg::*;
#(
	parameter int TALLY_WIDTH = 8
) (
	// clock and reset
	input  wire logic                   clock,
	input  wire logic                   reset_n,
	// management register access
	input  wire logic [4:0]             reg_addr,
	input  wire logic                   reg_write,
	input  wire logic                   reg_read,
	input  wire logic [15:0]            reg_wdata,
	output var  logic [15:0]            reg_rdata,
	output var  logic                   reg_rvalid,
	// receive path events
	input  wire logic                   false_carrier_event,
	input  wire logic                   rx_carrier_valid,
	input  wire logic                   rx_data_valid,
	input  wire logic                   rx_invalid_symbol,
	// self-test generator and checker
	input  wire logic                   checker_in_sync,
	input  wire logic                   checker_bit_error,
	input  wire logic                   generator_active,
	output var  logic                   generator_enable,
	output var  logic                   generator_continuous,
	output var  logic                   checker_enable,
	output var  logic [TALLY_WIDTH-1:0] error_tally,
	output var  logic                   error_tally_wrap,
	// mode and event outputs
	output var  logic                   mii_loopback,
	output var  logic                   false_carrier_half_event,
	output var  logic                   receive_error_half_event
);

	localparam logic [TALLY_WIDTH-1:0] TALLY_MAX = {TALLY_WIDTH{1'b1}};

	// one step of a counter that may be cleared by a read in the same cycle
	function automatic logic [15:0] count_step(input logic [15:0] value,
		input logic [15:0] limit, input logic inc, input logic clear);
		logic [15:0] result;
		result = value;
		if (clear) begin
			result = inc ? 16'h0001 : 16'h0000;
		end else if (inc && value < limit) begin
			result = 16'(value + 16'h0001);
		end
		return result;
	endfunction

	// state
	logic [7:0]             false_carrier_count;
	logic [15:0]            receive_error_count;
	logic                   error_tally_wrap_mode;
	logic [1:0]             checker_config_hi;
	logic                   checker_locked;
	logic                   checker_sync_lost;
	logic                   generator_running;
	pec_test_t              test_state;
	pec_test_t              next_test_state;

	// access decode
	wire logic              sel_basic   = reg_addr == PEC_ADDR_BASIC_CONTROL;
	wire logic              sel_fc      = reg_addr == PEC_ADDR_FALSE_CARRIER;
	wire logic              sel_rx      = reg_addr == PEC_ADDR_RX_ERROR;
	wire logic              sel_st      = reg_addr == PEC_ADDR_SELF_TEST;
	wire logic              fc_clear    = reg_read && sel_fc;
	wire logic              rx_clear    = reg_read && sel_rx;
	wire logic              st_read     = reg_read && sel_st;
	wire logic              st_write    = reg_write && sel_st;
	wire logic              basic_write = reg_write && sel_basic;

	// counting qualifiers
	wire logic              fc_inc = false_carrier_event; // R01
	wire logic              rx_inc = rx_carrier_valid && rx_data_valid
		&& rx_invalid_symbol && !mii_loopback; // R06 R07
	wire logic              tally_inc = checker_enable && checker_bit_error;
	wire logic              tally_at_max = error_tally == TALLY_MAX;

	wire logic [15:0]       next_fc_wide = count_step({8'h00, false_carrier_count},
		{8'h00, PEC_FC_MAX}, fc_inc, fc_clear); // R02 R19
	wire logic [7:0]        next_fc = next_fc_wide[7:0];
	wire logic [15:0]       next_rx = count_step(receive_error_count, PEC_RX_MAX,
		rx_inc, rx_clear); // R05 R08 R19

	wire logic              next_fc_half = !fc_clear && fc_inc
		&& false_carrier_count == PEC_FC_HALF; // R03
	wire logic              next_rx_half = !rx_clear && rx_inc
		&& receive_error_count == PEC_RX_HALF; // R09

	// self-test configuration after a write this cycle
	wire logic [1:0]        next_cfg = st_write
		? reg_wdata[PEC_CFG_HI_BIT:PEC_CFG_LO_BIT] : checker_config_hi;

	// sync is lost when a locked checker drops out of lock
	wire logic              sync_drop = checker_enable && checker_locked && !checker_in_sync;

	// register read view; unused bits stay zero
	wire logic [15:0]       fc_view = {8'h00, false_carrier_count}; // R20
	wire logic [15:0]       st_view = {1'b0, error_tally_wrap_mode, checker_config_hi,
		checker_locked, checker_sync_lost, generator_running,
		PEC_SELF_TEST_RESET[PEC_POWER_BIT], 8'h00}; // R15 R16 R18 R20
	wire logic [15:0]       read_mux = sel_fc ? fc_view
		: sel_rx ? receive_error_count
		: sel_st ? st_view
		: 16'h0000;

	always_comb begin
		case (next_cfg)
			PEC_CFG_OFF:    next_test_state = PEC_TEST_OFF;
			PEC_CFG_SINGLE: next_test_state = PEC_TEST_SINGLE;
			PEC_CFG_CHECK:  next_test_state = PEC_TEST_CHECK;
			PEC_CFG_BOTH:   next_test_state = PEC_TEST_BOTH;
			default:        next_test_state = PEC_TEST_OFF;
		endcase
	end

	// error counters
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			false_carrier_count      <= PEC_FALSE_CARRIER_RESET[7:0];
			receive_error_count      <= PEC_RX_ERROR_RESET;
			false_carrier_half_event <= 1'b0;
			receive_error_half_event <= 1'b0;
		end else begin
			false_carrier_count      <= next_fc; // R01 R02 R04
			receive_error_count      <= next_rx; // R05 R04
			false_carrier_half_event <= next_fc_half; // R03
			receive_error_half_event <= next_rx_half; // R09
		end
	end

	// register read port
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata  <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_read;
			if (reg_read) begin
				reg_rdata <= read_mux; // R04
			end
		end
	end

	// writable control fields
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			error_tally_wrap_mode <= PEC_SELF_TEST_RESET[PEC_WRAP_BIT];
			checker_config_hi     <= PEC_SELF_TEST_RESET[PEC_CFG_HI_BIT:PEC_CFG_LO_BIT];
			mii_loopback          <= 1'b0;
		end else begin
			if (st_write) begin
				error_tally_wrap_mode <= reg_wdata[PEC_WRAP_BIT];
			end
			checker_config_hi <= next_cfg;
			if (basic_write) begin
				mii_loopback <= reg_wdata[PEC_LOOPBACK_BIT]; // R17
			end
		end
	end

	// test mode and its enables
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			test_state           <= PEC_TEST_OFF;
			generator_enable     <= 1'b0;
			generator_continuous <= 1'b0;
			checker_enable       <= 1'b0;
		end else begin
			test_state           <= next_test_state;
			generator_enable     <= next_test_state == PEC_TEST_SINGLE
				|| next_test_state == PEC_TEST_BOTH; // R13 R14
			generator_continuous <= next_test_state == PEC_TEST_BOTH; // R14
			checker_enable       <= next_test_state == PEC_TEST_CHECK
				|| next_test_state == PEC_TEST_BOTH; // R12 R14
		end
	end

	// checker status
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			checker_locked    <= 1'b0;
			checker_sync_lost <= 1'b0;
			generator_running <= 1'b0;
		end else begin
			checker_locked    <= checker_enable && checker_in_sync; // R15
			generator_running <= generator_active; // R18
			if (sync_drop) begin
				checker_sync_lost <= 1'b1; // R16
			end else if (st_read) begin
				checker_sync_lost <= 1'b0;
			end
		end
	end

	// self-test error tally; held at zero while the checker is off
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			error_tally      <= '0;
			error_tally_wrap <= 1'b0;
		end else begin
			error_tally_wrap <= 1'b0;
			if (!checker_enable) begin
				error_tally <= '0;
			end else if (tally_inc && tally_at_max) begin
				if (error_tally_wrap_mode) begin
					error_tally      <= '0; // R11
					error_tally_wrap <= 1'b1; // R11
				end
			end else if (tally_inc) begin
				error_tally <= error_tally + 1'b1; // R10
			end
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);

	AST_FC_INC: assert property ( // R01
		(fc_inc && !fc_clear && false_carrier_count < PEC_FC_MAX)
		|=> false_carrier_count == 8'($past(false_carrier_count) + 8'h01))
		else $error("false carrier count did not step by one");

	AST_FC_SAT: assert property ( // R02
		(false_carrier_count == PEC_FC_MAX && !fc_clear)
		|=> false_carrier_count == PEC_FC_MAX)
		else $error("false carrier count left its maximum without a read");

	AST_FC_HALF: assert property ( // R03
		(fc_inc && !fc_clear && false_carrier_count == PEC_FC_HALF)
		|=> false_carrier_half_event && false_carrier_count == 8'h80)
		else $error("false carrier half-full event missing");

	AST_FC_NO_HALF: assert property ( // R03
		false_carrier_half_event |-> $past(false_carrier_count) == PEC_FC_HALF)
		else $error("false carrier half-full event at wrong count");

	AST_READ_CLEAR: assert property ( // R04
		(rx_clear && !rx_inc)
		|=> reg_rvalid && reg_rdata == $past(receive_error_count)
			&& receive_error_count == 16'h0000)
		else $error("receive error read did not return and clear");

	AST_READ_MEETS_EVENT: assert property ( // R19
		(fc_clear && fc_inc)
		|=> false_carrier_count == 8'h01 && reg_rdata[7:0] == $past(false_carrier_count))
		else $error("event coinciding with clearing read was lost");

	AST_RX_INC: assert property ( // R05
		(rx_inc && !rx_clear && receive_error_count < PEC_RX_MAX)
		|=> receive_error_count == 16'($past(receive_error_count) + 16'h0001))
		else $error("receive error count did not step by one");

	AST_RX_QUALIFY: assert property ( // R06
		(!(rx_carrier_valid && rx_data_valid && rx_invalid_symbol) && !rx_clear)
		|=> $stable(receive_error_count))
		else $error("receive error counted without qualifiers");

	AST_RX_LOOPBACK: assert property ( // R07
		(mii_loopback && !rx_clear) [*2] |=> $stable(receive_error_count))
		else $error("receive error counted in loopback");

	AST_RX_SAT: assert property ( // R08
		receive_error_count <= PEC_RX_MAX)
		else $error("receive error count passed its maximum");

	AST_RX_HALF: assert property ( // R09
		(rx_inc && !rx_clear && receive_error_count == PEC_RX_HALF)
		|=> receive_error_half_event ##1 !receive_error_half_event)
		else $error("receive error half-full event wrong");

	AST_TALLY_STOP: assert property ( // R10
		(checker_enable && !error_tally_wrap_mode && tally_at_max && !st_write)
		|=> error_tally == TALLY_MAX && !error_tally_wrap)
		else $error("self-test tally left maximum in stop mode");

	AST_TALLY_WRAP: assert property ( // R11
		(checker_enable && error_tally_wrap_mode && tally_at_max && tally_inc)
		|=> error_tally == '0 && error_tally_wrap)
		else $error("self-test tally did not wrap with a pulse");

	AST_CFG_CHECK: assert property ( // R12
		(st_write && reg_wdata[PEC_CFG_HI_BIT:PEC_CFG_LO_BIT] == PEC_CFG_CHECK)
		|=> checker_enable && !generator_enable)
		else $error("checker-only configuration not applied");

	AST_CFG_OFF: assert property ( // R12
		test_state == PEC_TEST_OFF |-> !checker_enable && !generator_enable)
		else $error("generator or checker on while disabled");

	AST_CFG_SINGLE: assert property ( // R13
		(st_write && reg_wdata[PEC_CFG_HI_BIT:PEC_CFG_LO_BIT] == PEC_CFG_SINGLE)
		|=> generator_enable && !generator_continuous && !checker_enable)
		else $error("single packet configuration not applied");

	AST_CFG_BOTH: assert property ( // R14
		test_state == PEC_TEST_BOTH
		|-> generator_enable && generator_continuous && checker_enable)
		else $error("continuous configuration not applied");

	AST_LOCK: assert property ( // R15
		(st_read ##1 1'b1) |-> reg_rdata[PEC_LOCK_BIT] == $past(checker_locked)
			&& $past(checker_locked) == ($past(checker_enable, 2)
			&& $past(checker_in_sync, 2)))
		else $error("lock bit does not follow the checker");

	AST_SYNC_LOSS: assert property ( // R16
		sync_drop |=> checker_sync_lost)
		else $error("sync loss not flagged");

	AST_SYNC_LOSS_CAUSE: assert property ( // R16
		$rose(checker_sync_lost) |-> $past(sync_drop))
		else $error("sync loss flagged without a drop");

	AST_LOOPBACK_ENTRY: assert property ( // R17
		basic_write |=> mii_loopback == $past(reg_wdata[PEC_LOOPBACK_BIT]))
		else $error("loopback bit not taken from basic control");

	AST_GEN_STATUS: assert property ( // R18
		st_read |=> reg_rdata[PEC_GEN_BIT] == $past(generator_running))
		else $error("generator status misreported");

	AST_RESERVED: assert property ( // R20
		(reg_read && (sel_fc || sel_st))
		|=> reg_rdata[15] == 1'b0 && reg_rdata[7:0] == ($past(sel_fc)
			? $past(false_carrier_count) : 8'h00))
		else $error("reserved bits read nonzero");

	AST_FC_HIGH_ZERO: assert property ( // R20
		fc_clear |=> reg_rdata[15:8] == 8'h00)
		else $error("false carrier upper bits read nonzero");

	AST_FC_HALF_PULSE: assert property ( // R03
		false_carrier_half_event |=> !false_carrier_half_event)
		else $error("false carrier half-full event longer than one cycle");

	AST_TALLY_OFF: assert property ( // R12
		!checker_enable |=> error_tally == '0 && !error_tally_wrap)
		else $error("self-test tally moved with the checker off");

	AST_SYNC_LOSS_CLEAR: assert property ( // R16
		(st_read && !sync_drop) |=> !checker_sync_lost)
		else $error("sync loss not cleared by a status read");

endmodule // pec_phy_error_counters

`default_nettype wire

// File: verilog/pec_pkg.sv
// How it works
// R01: an 8-bit false carrier counter adds one per false carrier event.
// R02: the false carrier counter holds at FFh instead of wrapping.
// R03: passing 7Fh in the false carrier counter raises an interrupt event.
// R04: reading either counter register returns the count, then clears it.
// R05: a 16-bit receive error counter adds one per detected receive error.
// R06: receive errors count only with valid carrier, data valid and bad symbol.
// R07: receive error counting is inhibited during MII loopback.
// R08: the receive error counter stops at its maximum, FFh.
// R09: passing 7Fh in the receive error counter raises an interrupt event.
// R10: wrap mode zero makes the self-test error tally stop at maximum.
// R11: wrap mode one pulses at maximum and restarts the tally at zero.
// R12: config zero disables generator and checker; two enables checker only.
// R13: config one sends one constant packet with the checker off.
// R14: config three enables generator and checker, sending packets continuously.
// R15: lock bit reads one while the checker is locked and synchronised.
// R16: sync loss bit goes one when the checker loses sync and stays one until a self-test status read clears it.
// R17: bit 14 of basic control at address zero enters MII loopback.
// R18: generator status bit reads one while packets are being generated.
// R19: an event that meets a clearing read survives as a count of one.
// R20: reserved bits of counter and self-test registers read zero.
`default_nettype none

package pec_pkg;

	// register addresses
	localparam logic [4:0]  PEC_ADDR_BASIC_CONTROL = 5'h00;
	localparam logic [4:0]  PEC_ADDR_FALSE_CARRIER = 5'h14;
	localparam logic [4:0]  PEC_ADDR_RX_ERROR      = 5'h15;
	localparam logic [4:0]  PEC_ADDR_SELF_TEST     = 5'h16;

	// reset values
	localparam logic [15:0] PEC_FALSE_CARRIER_RESET = 16'h0000;
	localparam logic [15:0] PEC_RX_ERROR_RESET      = 16'h0000;
	localparam logic [15:0] PEC_SELF_TEST_RESET     = 16'h0100;

	// field positions
	localparam int          PEC_LOOPBACK_BIT  = 14;
	localparam int          PEC_WRAP_BIT      = 14;
	localparam int          PEC_CFG_HI_BIT    = 13;
	localparam int          PEC_CFG_LO_BIT    = 12;
	localparam int          PEC_LOCK_BIT      = 11;
	localparam int          PEC_LOSS_BIT      = 10;
	localparam int          PEC_GEN_BIT       = 9;
	localparam int          PEC_POWER_BIT     = 8;

	// counter limits
	localparam logic [7:0]  PEC_FC_MAX  = 8'hFF;
	localparam logic [7:0]  PEC_FC_HALF = 8'h7F;
	localparam logic [15:0] PEC_RX_MAX  = 16'h00FF;
	localparam logic [15:0] PEC_RX_HALF = 16'h007F;

	// generator and checker configuration codes
	localparam logic [1:0]  PEC_CFG_OFF    = 2'h0;
	localparam logic [1:0]  PEC_CFG_SINGLE = 2'h1;
	localparam logic [1:0]  PEC_CFG_CHECK  = 2'h2;
	localparam logic [1:0]  PEC_CFG_BOTH   = 2'h3;

	typedef enum logic [3:0] {
		PEC_TEST_OFF    = 4'h1,
		PEC_TEST_SINGLE = 4'h2,
		PEC_TEST_CHECK  = 4'h4,
		PEC_TEST_BOTH   = 4'h8
	} pec_test_t;

endpackage

`default_nettype wire

// File: bench/pec_far_model.sv
`default_nettype none

module pec_far_model
	import pec_pkg::*;
#(
	parameter int PACKET_CYCLES = 20
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic reset_n,
	// controls from the block
	input  wire logic generator_enable,
	input  wire logic generator_continuous,
	input  wire logic checker_enable,
	// bench command: received stream is clean
	input  wire logic stream_good,
	// status back to the block
	output var  logic generator_active,
	output var  logic checker_in_sync
);
	timeunit 1ns;
	timeprecision 1ps;

	int   left;
	logic enable_seen;

	// single packet runs a fixed length, continuous runs while enabled
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			left             <= 0;
			enable_seen      <= 1'b0;
			generator_active <= 1'b0;
			checker_in_sync  <= 1'b0;
		end else begin
			enable_seen      <= generator_enable;
			checker_in_sync  <= checker_enable && stream_good;
			generator_active <= generator_enable && (generator_continuous || left > 0);
			if (!generator_enable)
				left <= 0;
			else if (!enable_seen)
				left <= PACKET_CYCLES;
			else if (left > 0)
				left <= left - 1;
		end
	end

endmodule // pec_far_model

`default_nettype wire

// File: bench/phy_error_counters_bist_tb.sv
`default_nettype none

module phy_error_counters_bist_tb
	import pec_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clock = 1'b0;
	logic        reset_n = 1'b0;
	logic [4:0]  reg_addr = 5'h00;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic        reg_rvalid;
	logic [2:0]  ev = 3'h0;
	logic        rx_carrier_valid = 1'b1;
	logic        rx_data_valid = 1'b1;
	logic        stream_good = 1'b0;
	logic        checker_in_sync, generator_active, generator_enable;
	logic        generator_continuous, checker_enable, error_tally_wrap, mii_loopback;
	logic        false_carrier_half_event, receive_error_half_event;
	logic [7:0]  error_tally;
	logic [15:0] d;
	int          fails = 0;
	int          checks = 0;
	int          fc_n = 0;
	int          rx_n = 0;
	int          wrap_n = 0;

	pec_phy_error_counters pec_phy_error_counters_i (.clock(clock), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.false_carrier_event(ev[0]), .rx_carrier_valid(rx_carrier_valid),
		.rx_data_valid(rx_data_valid), .rx_invalid_symbol(ev[1]),
		.checker_in_sync(checker_in_sync), .checker_bit_error(ev[2]),
		.generator_active(generator_active), .generator_enable(generator_enable),
		.generator_continuous(generator_continuous), .checker_enable(checker_enable),
		.error_tally(error_tally), .error_tally_wrap(error_tally_wrap),
		.mii_loopback(mii_loopback), .false_carrier_half_event(false_carrier_half_event),
		.receive_error_half_event(receive_error_half_event));

	pec_far_model pec_far_model_i (.clock(clock), .reset_n(reset_n),
		.generator_enable(generator_enable), .generator_continuous(generator_continuous),
		.checker_enable(checker_enable), .stream_good(stream_good),
		.generator_active(generator_active), .checker_in_sync(checker_in_sync));

	always #5 clock = ~clock;

	// count one-cycle event pulses
	always @(posedge clock) begin
		fc_n   += int'(false_carrier_half_event === 1'b1);
		rx_n   += int'(receive_error_half_event === 1'b1);
		wrap_n += int'(error_tally_wrap === 1'b1);
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		reg_addr  = a;
		reg_wdata = v;
		reg_write = 1'b1;
		idle(1);
		reg_write = 1'b0;
		idle(1);
	endtask

	// optional false carrier event in the same cycle as the read
	task automatic rd(input logic [4:0] a, input logic fc);
		reg_addr = a;
		reg_read = 1'b1;
		ev[0]    = fc;
		idle(1);
		reg_read = 1'b0;
		ev[0]    = 1'b0;
		chk("read valid", 16'(reg_rvalid), 16'h0001);
		d = reg_rdata;
		idle(1);
	endtask

	// hold the selected event inputs high for n cycles
	task automatic pulse(input logic [2:0] sel, input int n);
		ev = sel;
		idle(n);
		ev = 3'h0;
		idle(1);
	endtask

	function automatic logic [15:0] st(logic w, logic [1:0] c, logic lk, logic lo, logic g);
		return {1'b0, w, c, lk, lo, g, 1'b1, 8'h00};
	endfunction

	task automatic wait_gen_off();
		int i;
		for (i = 0; i < 200 && generator_active !== 1'b0; i++)
			idle(1);
		if (i == 200) begin
			fails++;
			$display("wrong value generator_active expected 0 seen 1");
			summarize();
		end
	endtask

	initial begin
		repeat (12) @(posedge clock);
		#1 reset_n = 1'b1;
		rd(5'h14, 1'b0); chk("fc reset", d, 16'h0000);
		rd(5'h15, 1'b0); chk("rx reset", d, 16'h0000);
		rd(5'h16, 1'b0); chk("self test reset", d, 16'h0100);
		rd(5'h1F, 1'b0); chk("unmapped", d, 16'h0000);
		wr(5'h14, 16'hFFFF);
		rd(5'h14, 1'b0); chk("fc write ignored", d, 16'h0000);
		$display("test registers done");

		pulse(3'h1, 127); chk("fc half early", 16'(fc_n), 16'h0000);
		pulse(3'h1, 1); chk("fc half", 16'(fc_n), 16'h0001);
		pulse(3'h1, 200); chk("fc half once", 16'(fc_n), 16'h0001);
		rd(5'h14, 1'b0); chk("fc saturate", d, 16'h00FF);
		rd(5'h14, 1'b0); chk("fc cleared", d, 16'h0000);
		pulse(3'h1, 2);
		rd(5'h14, 1'b1); chk("fc count", d, 16'h0002);
		rd(5'h14, 1'b0); chk("fc coincident", d, 16'h0001);
		$display("test false carrier done");

		rx_carrier_valid = 1'b0;
		pulse(3'h2, 4);
		rx_carrier_valid = 1'b1;
		rx_data_valid = 1'b0;
		pulse(3'h2, 4);
		rx_data_valid = 1'b1;
		wr(5'h00, 16'h4000); chk("loopback on", 16'(mii_loopback), 16'h0001);
		pulse(3'h2, 4);
		wr(5'h00, 16'h0000); chk("loopback off", 16'(mii_loopback), 16'h0000);
		rd(5'h15, 1'b0); chk("rx qualified", d, 16'h0000);
		pulse(3'h2, 3);
		rd(5'h15, 1'b0); chk("rx count", d, 16'h0003);
		pulse(3'h2, 128); chk("rx half", 16'(rx_n), 16'h0001);
		pulse(3'h2, 300);
		rd(5'h15, 1'b0); chk("rx saturate", d, 16'h00FF);
		rd(5'h15, 1'b0); chk("rx cleared", d, 16'h0000);
		$display("test receive errors done");

		for (int c = 0; c < 4; c++) begin
			wr(5'h16, {2'b00, c[1:0], 12'h000});
			chk("gen enable", 16'(generator_enable), 16'(c[0]));
			chk("continuous", 16'(generator_continuous), 16'(c == 3));
			chk("checker enable", 16'(checker_enable), 16'(c[1]));
			rd(5'h16, 1'b0); chk("config read", d & 16'hFDFF, st(1'b0, c[1:0], 1'b0, 1'b0, 1'b0));
		end
		wr(5'h16, 16'h0000);
		wr(5'h16, 16'h1000);
		idle(3);
		rd(5'h16, 1'b0); chk("gen status on", 16'(d[9]), 16'h0001);
		wait_gen_off();
		idle(3);
		rd(5'h16, 1'b0); chk("single done", d, st(1'b0, 2'h1, 1'b0, 1'b0, 1'b0));
		wr(5'h16, 16'h3000);
		idle(4);
		rd(5'h16, 1'b0); chk("continuous on", d, st(1'b0, 2'h3, 1'b0, 1'b0, 1'b1));
		$display("test configuration done");

		wr(5'h16, 16'h2000);
		stream_good = 1'b1;
		idle(4);
		rd(5'h16, 1'b0); chk("locked", d, st(1'b0, 2'h2, 1'b1, 1'b0, 1'b0));
		stream_good = 1'b0;
		idle(4);
		rd(5'h16, 1'b0); chk("sync lost", d, st(1'b0, 2'h2, 1'b0, 1'b1, 1'b0));
		rd(5'h16, 1'b0); chk("sync loss cleared", d, st(1'b0, 2'h2, 1'b0, 1'b0, 1'b0));
		$display("test lock done");

		wr(5'h16, 16'h0000);
		wr(5'h16, 16'h2000);
		pulse(3'h4, 260); chk("tally stop", 16'(error_tally), 16'h00FF);
		wr(5'h16, 16'h0000); chk("tally off", 16'(error_tally), 16'h0000);
		wr(5'h16, 16'h6000);
		pulse(3'h4, 255); chk("tally full", 16'(error_tally), 16'h00FF);
		chk("no wrap yet", 16'(wrap_n), 16'h0000);
		pulse(3'h4, 1);
		idle(2);
		chk("tally wrapped", 16'(error_tally), 16'h0000);
		chk("wrap pulse", 16'(wrap_n), 16'h0001);
		$display("test tally done");
		summarize();
	end

endmodule // phy_error_counters_bist_tb

`default_nettype wire
